// File: include/mrlr_pkg.sv
// shared constants for the memory-system region, lockdown and remap registers
package mrlr_pkg;
  // coprocessor register numbers and secondary selectors
  localparam logic [3:0] MRLR_CRN_REGION = 4'h9;
  localparam logic [3:0] MRLR_CRM_REGION = 4'h1;
  localparam logic [3:0] MRLR_CRN_LOCK = 4'hA;
  localparam logic [3:0] MRLR_CRM_LOCK = 4'h0;
  localparam logic [3:0] MRLR_CRN_PROC = 4'hD;
  localparam logic [3:0] MRLR_CRM_PROC = 4'h0;
  localparam logic [2:0] MRLR_OP2_DATA = 3'h0;
  localparam logic [2:0] MRLR_OP2_INSTR = 3'h1;
  localparam logic [2:0] MRLR_OP2_REMAP = 3'h0;
  localparam logic [2:0] MRLR_OP2_CTXID = 3'h1;
  localparam logic [2:0] MRLR_OP2_LOCK = 3'h0;
  // region register fields
  localparam int MRLR_BASE_LSB = 12;
  localparam int MRLR_SIZE_LSB = 2;
  localparam int MRLR_SIZE_MSB = 5;
  localparam int MRLR_EN_BIT = 0;
  // region size codes
  localparam logic [3:0] MRLR_SIZE_ABSENT = 4'h0;
  localparam logic [3:0] MRLR_SIZE_MIN = 4'h3;
  localparam logic [3:0] MRLR_SIZE_MAX = 4'hB;
  // lockdown register fields
  localparam int MRLR_PRESERVE_BIT = 0;
  localparam int MRLR_VICTIM_LSB = 26;
  localparam int MRLR_VICTIM_W = 3;
  localparam int MRLR_LOCK_ENTRIES = 8;
  // remap identifier field and slot size
  localparam int MRLR_PID_LSB = 25;
  localparam int MRLR_PID_W = 7;
  localparam logic [6:0] MRLR_PID_RESET = 7'h00;
  localparam logic [31:0] MRLR_CTXID_RESET = 32'h0000_0000;
  // page tag and subpage positions for the locked entries
  localparam int MRLR_SUB_LSB = 10;
  localparam int MRLR_SUB_W = 2;
endpackage

// File: rtl/mrlr_lock_tlb.sv
`timescale 1ns/1ps
// eight-entry fully associative locked translation region
module mrlr_lock_tlb
  import mrlr_pkg::*;
#(
  parameter int ENTRIES = MRLR_LOCK_ENTRIES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // entry write from a table walk
  input wire logic i_wr,
  input wire logic [MRLR_VICTIM_W-1:0] i_idx,
  input wire logic [31:0] i_va,
  input wire logic [19:0] i_pa,
  input wire logic i_sub_only,
  // single-entry invalidate by modified address
  input wire logic i_inv,
  input wire logic [31:0] i_inv_mva,
  // lookup
  input wire logic [31:0] i_look_mva,
  output logic o_hit,
  output logic [19:0] o_pa,
  output logic [ENTRIES-1:0] o_valid
);
  logic [ENTRIES-1:0] valid_q, valid_d; // entry valid flags
  logic [19:0] vtag_q [ENTRIES]; // virtual page tags
  logic [19:0] ptag_q [ENTRIES]; // physical page tags
  logic [ENTRIES-1:0] subonly_q; // entry covers one subpage only
  logic [MRLR_SUB_W-1:0] sub_q [ENTRIES]; // the subpage it covers

  // page match, narrowed to the subpage when permissions differ
  function automatic logic ent_match(input logic [19:0] tag, input logic so,
      input logic [MRLR_SUB_W-1:0] sub, input logic [31:0] a);
    ent_match = (tag == a[31:12]) && (!so || (sub == a[MRLR_SUB_LSB +: MRLR_SUB_W]));
  endfunction

  // valid flags: a write of the same entry beats an invalidate
  always_comb begin
    valid_d = valid_q;
    for (int i = 0; i < ENTRIES; i++) begin
      if (i_inv && valid_q[i] && ent_match(vtag_q[i], subonly_q[i], sub_q[i], i_inv_mva)) begin
        valid_d[i] = 1'b0;
      end
      if (i_wr && (i_idx == MRLR_VICTIM_W'(i))) begin
        valid_d[i] = 1'b1;
      end
    end
    if (i_rst) begin
      valid_d = '0;
    end
  end

  // entry storage; a single process owns every slot so each array has one driver
  always_ff @(posedge i_clock) begin
    for (int i = 0; i < ENTRIES; i++) begin
      if (i_wr && (i_idx == MRLR_VICTIM_W'(i))) begin
        vtag_q[i] <= i_va[31:12];
        ptag_q[i] <= i_pa;
        subonly_q[i] <= i_sub_only;
        sub_q[i] <= i_va[MRLR_SUB_LSB +: MRLR_SUB_W];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    valid_q <= valid_d;
  end

  // lookup; lowest-numbered matching entry wins
  always_comb begin
    o_hit = 1'b0;
    o_pa = 20'h00000;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (valid_q[i] && ent_match(vtag_q[i], subonly_q[i], sub_q[i], i_look_mva)) begin
        o_hit = 1'b1;
        o_pa = ptag_q[i];
      end
    end
  end
  assign o_valid = valid_q;
endmodule // mrlr_lock_tlb

// File: rtl/mrlr_regs.sv
`timescale 1ns/1ps
// How it works
// - region base in bits 31:12 decodes accesses
// - size field reads the size pins
// - size codes: 0 absent, 3..11 valid
// - bit zero enables the region
// - disabled region is never accessed
// - instruction memory also takes data accesses
// - fetch into data memory goes to main
// - preserve set: walk fills locked slot victim
// - preserve clear: walk fills set-associative part
// - locked region has eight indexed entries
// - invalidate-all spares the locked entries
// - single invalidate hits locked entries too
// - victim increments after each locked fill unless software writes it in the same cycle
// - differing subpages lock only one subpage
// - secondary opcode picks remap or context id
// - addresses below 32MB get pid slot added
// - remap identifier is seven bits wide
// - remap identifier resets to zero
// - no remapping while translation is off
// - maintenance addresses are never remapped
// - data memory enable resets off
// - instruction enable resets from boot pin
module mrlr_regs
  import mrlr_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // pins from outside the clock domain
  input wire logic [3:0] i_instr_region_size_pins,
  input wire logic [3:0] i_data_region_size_pins,
  input wire logic i_boot_from_tight_memory_pin,
  // coprocessor register transfer
  input wire logic i_cp_valid,
  input wire logic i_cp_write,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_coproc_secondary_reg,
  input wire logic [2:0] i_cp_op2,
  input wire logic [31:0] i_cp_wdata,
  output logic o_cp_done,
  output logic [31:0] o_cp_rdata,
  // core access path
  input wire logic i_mmu_enable,
  input wire logic i_acc_valid,
  input wire logic i_acc_ifetch,
  input wire logic i_acc_maint,
  input wire logic [31:0] i_acc_addr,
  output logic o_acc_valid,
  output logic [31:0] o_modified_virtual_address,
  output logic o_itcm_sel,
  output logic o_dtcm_sel,
  output logic o_main_sel,
  // table walk and translation buffer maintenance
  input wire logic i_walk_write,
  input wire logic [31:0] i_walk_va,
  input wire logic [19:0] i_walk_pa,
  input wire logic i_walk_sub_differ,
  input wire logic i_inv_all,
  input wire logic i_inv_entry,
  input wire logic [31:0] i_inv_mva,
  output logic o_main_tlb_write,
  output logic o_main_tlb_inv_all,
  output logic o_main_tlb_inv_entry,
  // locked region lookup
  output logic o_lock_hit,
  output logic [19:0] o_lock_pa,
  // remap identifier for the rest of the memory system
  output logic [MRLR_PID_W-1:0] o_process_remap_id
);
  logic boot_s1_q; // first sync stage, read only by the second
  logic boot_q; // synchronised boot pin
  logic [MRLR_PID_W-1:0] pid_q, pid_d; // fast_process_remap identifier
  logic [31:0] ctx_q, ctx_d; // context identifier
  logic preserve_q, preserve_d; // lockdown preserve bit
  logic [MRLR_VICTIM_W-1:0] victim_q, victim_d; // lockdown victim index
  logic [31:0] rdata_d; // read mux
  logic [31:0] mva_d; // modified address before register
  logic itcm_hit, dtcm_hit; // region decodes
  logic [31:0] ird, drd; // region read values
  logic wr_i, wr_d, wr_lock, wr_pid, wr_ctx; // write strobes
  logic lock_fill; // walk writes the locked region
  logic [19:0] lock_pa; // locked lookup result
  logic lock_hit; // locked lookup hit

  // one register select decode, shared by read and write paths
  function automatic logic sel(input logic [3:0] crn, input logic [3:0] coproc_secondary_reg,
      input logic [2:0] op2, input logic [3:0] n, input logic [3:0] m, input logic [2:0] o);
    sel = (crn == n) && (coproc_secondary_reg == m) && (op2 == o);
  endfunction

  // boot pin passes two flops before anything reads it
  always_ff @(posedge i_clock) begin
    boot_s1_q <= i_boot_from_tight_memory_pin;
    boot_q <= boot_s1_q;
  end

  // write strobes per register
  assign wr_d = i_cp_valid && i_cp_write
    && sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
           MRLR_CRN_REGION, MRLR_CRM_REGION, MRLR_OP2_DATA);
  assign wr_i = i_cp_valid && i_cp_write
    && sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
           MRLR_CRN_REGION, MRLR_CRM_REGION, MRLR_OP2_INSTR);
  assign wr_lock = i_cp_valid && i_cp_write
    && sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
           MRLR_CRN_LOCK, MRLR_CRM_LOCK, MRLR_OP2_LOCK);
  assign wr_pid = i_cp_valid && i_cp_write
    && sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
           MRLR_CRN_PROC, MRLR_CRM_PROC, MRLR_OP2_REMAP);
  assign wr_ctx = i_cp_valid && i_cp_write
    && sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
           MRLR_CRN_PROC, MRLR_CRM_PROC, MRLR_OP2_CTXID);

  // instruction region; enable reset value follows the boot pin
  mrlr_tcm_region u_itcm (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_size_pins(i_instr_region_size_pins),
    .i_reset_enable(boot_q),
    .i_wr(wr_i),
    .i_wdata(i_cp_wdata),
    .i_addr(mva_d),
    .o_rdata(ird),
    .o_hit(itcm_hit)
  );

  // data region; always comes out of reset disabled
  mrlr_tcm_region u_dtcm (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_size_pins(i_data_region_size_pins),
    .i_reset_enable(1'b0),
    .i_wr(wr_d),
    .i_wdata(i_cp_wdata),
    .i_addr(mva_d),
    .o_rdata(drd),
    .o_hit(dtcm_hit)
  );

  // walk routing: preserve steers the entry to the locked slot
  assign lock_fill = i_walk_write && preserve_q;

  mrlr_lock_tlb u_lock (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_wr(lock_fill),
    .i_idx(victim_q),
    .i_va(i_walk_va),
    .i_pa(i_walk_pa),
    .i_sub_only(i_walk_sub_differ),
    .i_inv(i_inv_entry),
    .i_inv_mva(i_inv_mva),
    .i_look_mva(mva_d),
    .o_hit(lock_hit),
    .o_pa(lock_pa),
    .o_valid()
  );

  // control registers next values; a fill in the same cycle as a
  // software write loses its increment, software wins the victim
  always_comb begin
    pid_d = pid_q;
    ctx_d = ctx_q;
    preserve_d = preserve_q;
    victim_d = victim_q;
    if (lock_fill) begin
      victim_d = victim_q + 3'h1;
    end
    if (wr_lock) begin
      preserve_d = i_cp_wdata[MRLR_PRESERVE_BIT];
      victim_d = i_cp_wdata[MRLR_VICTIM_LSB +: MRLR_VICTIM_W];
    end
    if (wr_pid) begin
      pid_d = i_cp_wdata[MRLR_PID_LSB +: MRLR_PID_W];
    end
    if (wr_ctx) begin
      ctx_d = i_cp_wdata;
    end
    if (i_rst) begin
      pid_d = MRLR_PID_RESET;
      ctx_d = MRLR_CTXID_RESET;
      preserve_d = 1'b0;
      victim_d = 3'h0;
    end
  end

  always_ff @(posedge i_clock) begin
    pid_q <= pid_d;
    ctx_q <= ctx_d;
    preserve_q <= preserve_d;
    victim_q <= victim_d;
  end

  // read mux; unmapped selections read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
            MRLR_CRN_REGION, MRLR_CRM_REGION, MRLR_OP2_DATA)) begin
      rdata_d = drd;
    end else if (sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
                     MRLR_CRN_REGION, MRLR_CRM_REGION, MRLR_OP2_INSTR)) begin
      rdata_d = ird;
    end else if (sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
                     MRLR_CRN_LOCK, MRLR_CRM_LOCK, MRLR_OP2_LOCK)) begin
      rdata_d[MRLR_VICTIM_LSB +: MRLR_VICTIM_W] = victim_q;
      rdata_d[MRLR_PRESERVE_BIT] = preserve_q;
    end else if (sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
                     MRLR_CRN_PROC, MRLR_CRM_PROC, MRLR_OP2_REMAP)) begin
      rdata_d[MRLR_PID_LSB +: MRLR_PID_W] = pid_q;
    end else if (sel(i_cp_crn, i_cp_coproc_secondary_reg, i_cp_op2,
                     MRLR_CRN_PROC, MRLR_CRM_PROC, MRLR_OP2_CTXID)) begin
      rdata_d = ctx_q;
    end
  end

  // address remap: only low 32MB, only with translation on,
  // never for maintenance addresses
  always_comb begin
    mva_d = i_acc_addr;
    if (i_mmu_enable && !i_acc_maint
        && (i_acc_addr[31:MRLR_PID_LSB] == 7'h00)) begin
      mva_d = {pid_q, i_acc_addr[MRLR_PID_LSB-1:0]};
    end
  end

  // registered outputs; overlapping regions favour instruction side,
  // which software must avoid anyway
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cp_done <= 1'b0;
      o_cp_rdata <= 32'h0000_0000;
      o_acc_valid <= 1'b0;
      o_modified_virtual_address <= 32'h0000_0000;
      o_itcm_sel <= 1'b0;
      o_dtcm_sel <= 1'b0;
      o_main_sel <= 1'b0;
      o_main_tlb_write <= 1'b0;
      o_main_tlb_inv_all <= 1'b0;
      o_main_tlb_inv_entry <= 1'b0;
      o_lock_hit <= 1'b0;
      o_lock_pa <= 20'h00000;
    end else begin
      o_cp_done <= i_cp_valid;
      o_cp_rdata <= (i_cp_valid && !i_cp_write) ? rdata_d : 32'h0000_0000;
      o_acc_valid <= i_acc_valid;
      o_modified_virtual_address <= mva_d;
      o_itcm_sel <= i_acc_valid && itcm_hit;
      o_dtcm_sel <= i_acc_valid && dtcm_hit && !itcm_hit && !i_acc_ifetch;
      o_main_sel <= i_acc_valid && !itcm_hit && !(dtcm_hit && !i_acc_ifetch);
      o_main_tlb_write <= i_walk_write && !preserve_q;
      o_main_tlb_inv_all <= i_inv_all;
      o_main_tlb_inv_entry <= i_inv_entry;
      o_lock_hit <= lock_hit;
      o_lock_pa <= lock_pa;
    end
  end
  assign o_process_remap_id = pid_q;

  // checks
  property p_pid_reset;
    @(posedge i_clock) i_rst |=> (pid_q == 7'h00);
  endproperty
  a_pid_reset: assert property (p_pid_reset) else $error("remap id not zero after reset");

  property p_remap_low;
    @(posedge i_clock) disable iff (i_rst)
      (i_mmu_enable && !i_acc_maint && i_acc_addr[31:25] == 7'h00)
      |=> (o_modified_virtual_address == {$past(pid_q), $past(i_acc_addr[24:0])});
  endproperty
  a_remap_low: assert property (p_remap_low) else $error("low address not remapped");

  property p_no_remap_off;
    @(posedge i_clock) disable iff (i_rst)
      !i_mmu_enable |=> (o_modified_virtual_address == $past(i_acc_addr));
  endproperty
  a_no_remap_off: assert property (p_no_remap_off) else $error("remap while translation off");

  property p_no_remap_maint;
    @(posedge i_clock) disable iff (i_rst)
      i_acc_maint |=> (o_modified_virtual_address == $past(i_acc_addr));
  endproperty
  a_no_remap_maint: assert property (p_no_remap_maint) else $error("maintenance address remapped");

  property p_victim_inc;
    @(posedge i_clock) disable iff (i_rst)
      (lock_fill && !wr_lock) |=> (victim_q == $past(victim_q) + 3'h1);
  endproperty
  a_victim_inc: assert property (p_victim_inc) else $error("victim did not increment");

  property p_walk_main;
    @(posedge i_clock) disable iff (i_rst)
      (i_walk_write && !preserve_q && !wr_lock) |=> (o_main_tlb_write && $stable(victim_q));
  endproperty
  a_walk_main: assert property (p_walk_main) else $error("walk not sent to main buffer");

  property p_fetch_not_dtcm;
    @(posedge i_clock) disable iff (i_rst)
      (i_acc_valid && i_acc_ifetch && dtcm_hit && !itcm_hit) |=> (o_main_sel && !o_dtcm_sel);
  endproperty
  a_fetch_not_dtcm: assert property (p_fetch_not_dtcm) else $error("fetch reached data memory");

  property p_dtcm_off_reset;
    @(posedge i_clock) i_rst |=> (drd[MRLR_EN_BIT] == 1'b0);
  endproperty
  a_dtcm_off_reset: assert property (p_dtcm_off_reset) else $error("data memory enabled at reset");

  property p_disabled_unused;
    @(posedge i_clock) disable iff (i_rst)
      !drd[MRLR_EN_BIT] |=> !o_dtcm_sel;
  endproperty
  a_disabled_unused: assert property (p_disabled_unused) else $error("disabled memory selected");

  c_lock_fill: cover property (@(posedge i_clock) disable iff (i_rst) lock_fill ##1 lock_fill);
  c_remap_hit: cover property (@(posedge i_clock) disable iff (i_rst)
    i_mmu_enable && pid_q != 7'h00 && i_acc_valid);
  c_itcm_data: cover property (@(posedge i_clock) disable iff (i_rst)
    o_itcm_sel && !$past(i_acc_ifetch));
endmodule // mrlr_regs

// File: rtl/mrlr_tcm_region.sv
`timescale 1ns/1ps
// one tight-memory region register with its address decode
module mrlr_tcm_region
  import mrlr_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // size pins (asynchronous) and reset enable value
  input wire logic [3:0] i_size_pins,
  input wire logic i_reset_enable,
  // register write
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  // address to decode
  input wire logic [31:0] i_addr,
  // read value and decode result
  output logic [31:0] o_rdata,
  output logic o_hit
);
  logic [3:0] size_s1_q; // first sync stage, read only by the second
  logic [3:0] size_q; // synchronised size pins
  logic [19:0] base_q, base_d; // region base address
  logic en_q, en_d; // region enable

  // size mask over the 20 base bits; zero mask bits cover the region
  function automatic logic [19:0] size_mask(input logic [3:0] code);
    logic [19:0] ones;
    ones = 20'hFFFFF;
    size_mask = ones << (code - MRLR_SIZE_MIN);
  endfunction

  // next values: base and enable follow software, size never stored
  always_comb begin
    base_d = base_q;
    en_d = en_q;
    if (i_rst) begin
      base_d = 20'h00000;
      en_d = i_reset_enable;
    end else if (i_wr) begin
      base_d = i_wdata[31:MRLR_BASE_LSB];
      en_d = i_wdata[MRLR_EN_BIT];
    end
  end

  // registers; the size sync chain needs no reset
  always_ff @(posedge i_clock) begin
    size_s1_q <= i_size_pins;
    size_q <= size_s1_q;
    base_q <= base_d;
    en_q <= en_d;
  end

  // reserved bits read zero, size reflects the pins
  assign o_rdata = {base_q, 6'h00, size_q, 1'b0, en_q};

  // a reserved or absent size decodes nothing
  assign o_hit = en_q && (size_q >= MRLR_SIZE_MIN) && (size_q <= MRLR_SIZE_MAX)
    && (((i_addr[31:MRLR_BASE_LSB] ^ base_q) & size_mask(size_q)) == 20'h00000);
endmodule // mrlr_tcm_region

// File: tb/mrlr_regs_tb.sv
`timescale 1ns/1ps
// self-checking bench for the region, lockdown and remap registers
module mrlr_regs_tb
  import mrlr_pkg::*;
;
  // clock, reset and stimulus
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_instr_region_size_pins = 4'h5;
  logic [3:0] i_data_region_size_pins = 4'h3;
  logic i_boot_from_tight_memory_pin = 1'b1;
  logic i_cp_valid = 1'b0, i_cp_write = 1'b0;
  logic [3:0] i_cp_crn = 4'h0, i_cp_coproc_secondary_reg = 4'h0;
  logic [2:0] i_cp_op2 = 3'h0;
  logic [31:0] i_cp_wdata = 32'h0;
  logic i_mmu_enable = 1'b0, i_acc_valid = 1'b0, i_acc_ifetch = 1'b0, i_acc_maint = 1'b0;
  logic [31:0] i_acc_addr = 32'h0, i_walk_va = 32'h0, i_inv_mva = 32'h0;
  logic i_walk_write = 1'b0, i_walk_sub_differ = 1'b0, i_inv_all = 1'b0, i_inv_entry = 1'b0;
  logic [19:0] i_walk_pa = 20'h0;
  // observed outputs
  logic o_cp_done, o_acc_valid, o_itcm_sel, o_dtcm_sel, o_main_sel;
  logic [31:0] o_cp_rdata, o_modified_virtual_address;
  logic o_main_tlb_write, o_main_tlb_inv_all, o_main_tlb_inv_entry, o_lock_hit;
  logic [19:0] o_lock_pa;
  logic [MRLR_PID_W-1:0] o_process_remap_id;
  // bookkeeping; the ceiling is far above the 150 or so cycles used
  int fails = 0, total_checks = 0, cycles = 0;
  localparam int LIMIT = 5000;

  mrlr_regs i_mrlr_regs (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_instr_region_size_pins(i_instr_region_size_pins),
    .i_data_region_size_pins(i_data_region_size_pins),
    .i_boot_from_tight_memory_pin(i_boot_from_tight_memory_pin),
    .i_cp_valid(i_cp_valid),
    .i_cp_write(i_cp_write),
    .i_cp_crn(i_cp_crn),
    .i_cp_coproc_secondary_reg(i_cp_coproc_secondary_reg),
    .i_cp_op2(i_cp_op2),
    .i_cp_wdata(i_cp_wdata),
    .o_cp_done(o_cp_done),
    .o_cp_rdata(o_cp_rdata),
    .i_mmu_enable(i_mmu_enable),
    .i_acc_valid(i_acc_valid),
    .i_acc_ifetch(i_acc_ifetch),
    .i_acc_maint(i_acc_maint),
    .i_acc_addr(i_acc_addr),
    .o_acc_valid(o_acc_valid),
    .o_modified_virtual_address(o_modified_virtual_address),
    .o_itcm_sel(o_itcm_sel),
    .o_dtcm_sel(o_dtcm_sel),
    .o_main_sel(o_main_sel),
    .i_walk_write(i_walk_write),
    .i_walk_va(i_walk_va),
    .i_walk_pa(i_walk_pa),
    .i_walk_sub_differ(i_walk_sub_differ),
    .i_inv_all(i_inv_all),
    .i_inv_entry(i_inv_entry),
    .i_inv_mva(i_inv_mva),
    .o_main_tlb_write(o_main_tlb_write),
    .o_main_tlb_inv_all(o_main_tlb_inv_all),
    .o_main_tlb_inv_entry(o_main_tlb_inv_entry),
    .o_lock_hit(o_lock_hit),
    .o_lock_pa(o_lock_pa),
    .o_process_remap_id(o_process_remap_id)
  );

  // 250 MHz clock
  always #2 i_clock = ~i_clock;

  // hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      results();
    end
  end

  // single place where the run ends
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one register transfer; a write answers with zero data
  task automatic cp(input logic wr, input logic [3:0] crn, input logic [3:0] coproc_secondary_reg,
                    input logic [2:0] op2, input logic [31:0] wd, input logic [31:0] exp);
    @(negedge i_clock);
    i_cp_valid = 1'b1;
    i_cp_write = wr;
    i_cp_crn = crn;
    i_cp_coproc_secondary_reg = coproc_secondary_reg;
    i_cp_op2 = op2;
    i_cp_wdata = wd;
    @(negedge i_clock);
    check({31'h0, o_cp_done}, 32'h1);
    check(o_cp_rdata, wr ? 32'h0 : exp);
    i_cp_valid = 1'b0;
  endtask

  // one core access; sel is {instr, data, main}
  task automatic acc(input logic [31:0] a, input logic f, input logic m,
                     input logic [31:0] modified_virtual_address, input logic [2:0] sel);
    @(negedge i_clock);
    i_acc_valid = 1'b1;
    i_acc_ifetch = f;
    i_acc_maint = m;
    i_acc_addr = a;
    @(negedge i_clock);
    check({28'h0, o_acc_valid, o_itcm_sel, o_dtcm_sel, o_main_sel}, {28'h0, 1'b1, sel});
    check(o_modified_virtual_address, modified_virtual_address);
    i_acc_valid = 1'b0;
  endtask

  // locked lookup, result registered on the same edge as the modified address
  task automatic look(input logic [31:0] a, input logic hit, input logic [19:0] pa);
    acc(a, 1'b0, 1'b0, a, 3'b001);
    @(negedge i_clock);
    check({31'h0, o_lock_hit}, {31'h0, hit});
    if (hit) check({12'h0, o_lock_pa}, {12'h0, pa});
  endtask

  // table walk pulse; main buffer write expected only when not preserved
  task automatic walk(input logic [31:0] va, input logic [19:0] pa, input logic sd,
                      input logic main_exp);
    @(negedge i_clock);
    i_walk_write = 1'b1;
    i_walk_va = va;
    i_walk_pa = pa;
    i_walk_sub_differ = sd;
    @(negedge i_clock);
    check({31'h0, o_main_tlb_write}, {31'h0, main_exp});
    i_walk_write = 1'b0;
  endtask

  // invalidate pulse, all or single entry
  task automatic inv(input logic all, input logic [31:0] modified_virtual_address);
    @(negedge i_clock);
    i_inv_all = all;
    i_inv_entry = ~all;
    i_inv_mva = modified_virtual_address;
    @(negedge i_clock);
    check({30'h0, o_main_tlb_inv_all, o_main_tlb_inv_entry}, {30'h0, all, ~all});
    i_inv_all = 1'b0;
    i_inv_entry = 1'b0;
  endtask

  // reset held 16 cycles, driven off the sampling edge
  task automatic do_reset();
    i_rst = 1'b1;
    repeat (16) @(negedge i_clock);
    i_rst = 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // main sequence
  initial begin
    do_reset();
    // reset values and an unmapped select
    cp(0, 4'h9, 4'h1, 3'h1, 32'h0, 32'h0000_0015);
    cp(0, 4'h9, 4'h1, 3'h0, 32'h0, 32'h0000_000C);
    cp(0, 4'hD, 4'h0, 3'h0, 32'h0, 32'h0);
    cp(0, 4'hA, 4'h0, 3'h0, 32'h0, 32'h0);
    cp(1, 4'hB, 4'h0, 3'h0, 32'hFFFF_FFFF, 32'h0);
    cp(0, 4'hB, 4'h0, 3'h0, 32'h0, 32'h0);
    done("reset");
    // region registers: reserved bits dropped, size from pins;
    // bases are size-aligned and the two ranges stay apart
    cp(1, 4'h9, 4'h1, 3'h0, 32'h0020_0FFF, 32'h0);
    cp(0, 4'h9, 4'h1, 3'h0, 32'h0, 32'h0020_000D);
    cp(1, 4'h9, 4'h1, 3'h1, 32'h0010_0001, 32'h0);
    cp(0, 4'h9, 4'h1, 3'h1, 32'h0, 32'h0010_0015);
    acc(32'h0020_0010, 0, 0, 32'h0020_0010, 3'b010);
    acc(32'h0020_0010, 1, 0, 32'h0020_0010, 3'b001);
    acc(32'h0010_0020, 0, 0, 32'h0010_0020, 3'b100);
    acc(32'h0010_0020, 1, 0, 32'h0010_0020, 3'b100);
    acc(32'h0020_1000, 0, 0, 32'h0020_1000, 3'b001);
    // a reserved size code must never decode
    i_data_region_size_pins = 4'hC;
    repeat (4) @(negedge i_clock);
    cp(0, 4'h9, 4'h1, 3'h0, 32'h0, 32'h0020_0031);
    acc(32'h0020_0010, 0, 0, 32'h0020_0010, 3'b001);
    i_data_region_size_pins = 4'h3;
    repeat (4) @(negedge i_clock);
    // disabled region is left alone
    cp(1, 4'h9, 4'h1, 3'h0, 32'h0020_0000, 32'h0);
    acc(32'h0020_0010, 0, 0, 32'h0020_0010, 3'b001);
    done("region");
    // remap identifier and context id
    cp(1, 4'hD, 4'h0, 3'h0, 32'h0A00_0000, 32'h0);
    cp(1, 4'hD, 4'h0, 3'h1, 32'hCAFE_0001, 32'h0);
    cp(0, 4'hD, 4'h0, 3'h0, 32'h0, 32'h0A00_0000);
    cp(0, 4'hD, 4'h0, 3'h1, 32'h0, 32'hCAFE_0001);
    check({25'h0, o_process_remap_id}, 32'h5);
    acc(32'h0000_1000, 0, 0, 32'h0000_1000, 3'b001);
    i_mmu_enable = 1'b1;
    acc(32'h0000_1000, 0, 0, 32'h0A00_1000, 3'b001);
    acc(32'h0200_0000, 0, 0, 32'h0200_0000, 3'b001);
    acc(32'h0000_1000, 0, 1, 32'h0000_1000, 3'b001);
    cp(1, 4'hD, 4'h0, 3'h0, 32'hFE00_0000, 32'h0);
    cp(0, 4'hD, 4'h0, 3'h0, 32'h0, 32'hFE00_0000);
    acc(32'h01FF_FFFC, 0, 0, 32'hFFFF_FFFC, 3'b001);
    i_mmu_enable = 1'b0;
    done("remap");
    // locked region: victim wraps from 7, lookups and invalidates
    cp(1, 4'hA, 4'h0, 3'h0, 32'h1C00_0001, 32'h0);
    cp(0, 4'hA, 4'h0, 3'h0, 32'h0, 32'h1C00_0001);
    walk(32'h0030_0000, 20'hABCDE, 1'b0, 1'b0);
    cp(0, 4'hA, 4'h0, 3'h0, 32'h0, 32'h0000_0001);
    look(32'h0030_0000, 1'b1, 20'hABCDE);
    inv(1'b1, 32'h0);
    look(32'h0030_0000, 1'b1, 20'hABCDE);
    inv(1'b0, 32'h0030_0000);
    look(32'h0030_0000, 1'b0, 20'h0);
    walk(32'h0030_0400, 20'h12345, 1'b1, 1'b0);
    look(32'h0030_0400, 1'b1, 20'h12345);
    look(32'h0030_0000, 1'b0, 20'h0);
    cp(1, 4'hA, 4'h0, 3'h0, 32'h0800_0000, 32'h0);
    walk(32'h0040_0000, 20'h55555, 1'b0, 1'b1);
    cp(0, 4'hA, 4'h0, 3'h0, 32'h0, 32'h0800_0000);
    look(32'h0040_0000, 1'b0, 20'h0);
    done("lockdown");
    // second reset with the boot pin low
    i_boot_from_tight_memory_pin = 1'b0;
    do_reset();
    cp(0, 4'h9, 4'h1, 3'h1, 32'h0, 32'h0000_0014);
    cp(0, 4'hD, 4'h0, 3'h0, 32'h0, 32'h0);
    look(32'h0030_0400, 1'b0, 20'h0);
    done("rereset");
    results();
  end
endmodule // mrlr_regs_tb
